// *** logic/acmsc_defs.vh ***
`ifndef ACMSC_DEFS_VH
`define ACMSC_DEFS_VH
// Overview of operation
// RULE1: low_power_enable_bit/high_resolution_bit pick 8, 10 or 12 bit; both set forbidden.
// RULE2: bandwidth is ODR/2 in low power and normal, ODR/9 in high resolution.
// RULE3: turn-on: 1 ms low power, 1.6 ms normal, seven ODR periods high resolution.
// RULE4: resolution change waits seven ODR periods into 12 bit, else one.
// RULE5: self-test output is real acceleration plus the test force.
// RULE6: orientation event when stable in a known direction; 4D ignores Z.
// RULE7: host programs activity threshold and duration registers for sleep-to-wake.
// RULE8: below activity threshold the device falls to low power at 10 Hz.
// RULE9: during the fallback, programmed rate and resolution bits are ignored.
// RULE10: above threshold again, programmed mode and rate are restored.
// RULE11: sample_ready_flag rises whenever a complete new X, Y, Z set exists.
// RULE12: wake-up and free-fall events, shown together on two pins; the code puts wake-up on eventPinOne and free-fall on eventPinTwo only.
// RULE13: factory trimming is copied from non-volatile storage at power-up.
// RULE14: 32-level FIFO of 10-bit entries with FIFO, stream, trigger, bypass.
// RULE15: bypass keeps the FIFO empty; FIFO mode stores X, Y and Z.
// RULE16: temperature data is produced only while temperature_enable is one.
// RULE17: host sets block_update_hold and reads both temperature bytes.
// RULE18: temperature high byte holds 8-bit two's complement, left justified.
// RULE19: acceleration is two's complement, zero reads as zero.
// RULE20: host holds interface_select high when using I2C.

`define ACMSC_A_TEMPL 7'h0c
`define ACMSC_A_TEMPH 7'h0d
`define ACMSC_A_TEMPCFG 7'h1f
`define ACMSC_A_RATEPWR 7'h20
`define ACMSC_A_CTRL3 7'h22
`define ACMSC_A_RESUPD 7'h23
`define ACMSC_A_STATUS 7'h27
`define ACMSC_A_OUTXL 7'h28
`define ACMSC_A_OUTZH 7'h2d
`define ACMSC_A_FIFOCTL 7'h2e
`define ACMSC_A_FIFOSRC 7'h2f
`define ACMSC_A_EVCFG 7'h30
`define ACMSC_A_EVSRC 7'h31
`define ACMSC_A_WAKETHR 7'h32
`define ACMSC_A_FFTHR 7'h36
`define ACMSC_A_ACTTHR 7'h3e
`define ACMSC_A_ACTDUR 7'h3f

`define ACMSC_B_LOWPWR 3
`define ACMSC_B_HIRES 3
`define ACMSC_B_HOLD 7
`define ACMSC_B_TEMPEN 6
`define ACMSC_B_READY 3
`define ACMSC_B_PIN1WAKE 6
`define ACMSC_B_PIN1RDY 4
`define ACMSC_B_EV6D 6
`define ACMSC_B_EV4D 7

`define ACMSC_RST_RATEPWR 8'h07
`define ACMSC_RST_ZERO 8'h00

`define ACMSC_RES_LP 2'h0
`define ACMSC_RES_NM 2'h1
`define ACMSC_RES_HI 2'h2

`define ACMSC_FM_BYPASS 2'h0
`define ACMSC_FM_FIFO 2'h1
`define ACMSC_FM_STREAM 2'h2
`define ACMSC_FM_TRIG 2'h3

`define ACMSC_ODR_OFF 4'h0
`define ACMSC_ODR_10HZ 4'h2

`define ACMSC_CLK_PS 4000
`define ACMSC_TON_LP_PS 1000000000
`define ACMSC_TON_NM_PS 1600000000
`define ACMSC_SKIP_HI 3'h7
`define ACMSC_SKIP_OTHER 3'h1
`define ACMSC_TRIM_WORDS 2'h3
`endif

// *** logic/acmsc_core.v ***
`timescale 1ns/1ns
`include "acmsc_defs.vh"
module acmsc_core #(
    parameter TON_LP_CYC = (`ACMSC_TON_LP_PS + `ACMSC_CLK_PS - 1)
        / `ACMSC_CLK_PS,
    parameter TON_NM_CYC = (`ACMSC_TON_NM_PS + `ACMSC_CLK_PS - 1)
        / `ACMSC_CLK_PS,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5
) (
    input wire clk, // 250 MHz
    input wire rst_n, // async reset, active low
    input wire regWr, // register write strobe
    input wire regRd, // register read strobe
    input wire [6:0] regAddr, // register address
    input wire [7:0] regWdata, // write data
    output reg [7:0] regRdata, // read data, one cycle after regRd
    input wire smpValid, // pulse: new X, Y, Z conversion
    input wire [11:0] smpX, // raw X, two's complement
    input wire [11:0] smpY, // raw Y
    input wire [11:0] smpZ, // raw Z
    input wire [11:0] stForce, // test force magnitude, same scale
    input wire [7:0] tempRaw, // temperature conversion
    input wire [11:0] trimData, // storage word, one cycle after address
    output reg [1:0] trimAddr, // storage word address
    output reg trimBusy, // trimming download in progress
    output reg [3:0] odrSel, // effective output rate to converter
    output reg [1:0] resSel, // effective resolution
    output reg bwSel, // 1: bandwidth ODR/9, 0: ODR/2
    output reg sleepActive, // automatic low-power fallback active
    output reg dataReady, // new valid sample set level
    output reg eventPinOne, // wake-up / orientation / ready pin
    output reg eventPinTwo // free-fall pin
);

reg rstS1, rstS2;
wire rstI_n = rstS2;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rstS1 <= 1'b0;
        rstS2 <= 1'b0;
    end else begin
        rstS1 <= 1'b1;
        rstS2 <= rstS1;
    end
end
reg [7:0] ratePwr_r, ctrl3_r, resUpd_r, tempCfg_r, fifoCtl_r, evCfg_r;
reg [7:0] wakeThr_r, ffThr_r, actThr_r, actDur_r;
reg [11:0] trimOff_r [0:2];
reg [2:0] trimStep_r;
reg readyFlag_r, sleep_r, trigHit_r, tempLock_r;
reg [7:0] durCnt_r, tempOut_r, tempHold_r, evSrc_r;
reg [15:0] outReg_r [0:2];
reg [19:0] waitCyc_r;
reg [2:0] waitSmp_r;
reg [5:0] orientPrev_r, orientRep_r;
reg [9:0] fifoMem [0:3*FIFO_DEPTH-1];
reg [FIFO_AW-1:0] wrPtr_r, rdPtr_r;
reg [FIFO_AW:0] fifoCnt_r;
wire wrHit = regWr & ~trimBusy;
wire [1:0] fifoMode = fifoCtl_r[7:6];
wire rdZh = regRd & (regAddr == `ACMSC_A_OUTZH);
// effective mode: fallback overrides programmed bits
wire lpProg = ratePwr_r[`ACMSC_B_LOWPWR];
wire hiResProg = resUpd_r[`ACMSC_B_HIRES];
wire [1:0] resProg = (lpProg & ~hiResProg) ? `ACMSC_RES_LP :
    (~lpProg & hiResProg) ? `ACMSC_RES_HI : `ACMSC_RES_NM; // RULE1
wire [1:0] resEff = sleep_r ? `ACMSC_RES_LP : resProg; // RULE9 RULE10
wire [3:0] odrEff = sleep_r ? `ACMSC_ODR_10HZ : ratePwr_r[7:4]; // RULE8
// corrected samples and per-axis flags
wire [11:0] corr [0:2];
wire [11:0] absv [0:2];
wire [2:0] axHi, axLo, axFf;
wire [11:0] wakeLim = {1'b0, wakeThr_r[6:0], 4'h0};
wire [11:0] ffLim = {1'b0, ffThr_r[6:0], 4'h0};
wire [11:0] actLim = {1'b0, actThr_r[6:0], 4'h0};
wire [1:0] stMode = resUpd_r[2:1];
genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : gAxis
        wire [11:0] raw = (g == 0) ? smpX : (g == 1) ? smpY : smpZ;
        wire [11:0] st = (stMode == 2'h1) ? stForce :
            (stMode == 2'h2) ? (12'h000 - stForce) : 12'h000;
        // sensor plus test force, then factory offset removed
        assign corr[g] = raw + st - trimOff_r[g]; // RULE5 RULE13
        assign absv[g] = corr[g][11] ? (12'h000 - corr[g]) : corr[g];
        assign axHi[g] = ~corr[g][11] & (absv[g] > wakeLim);
        assign axLo[g] = corr[g][11] & (absv[g] > wakeLim);
        assign axFf[g] = absv[g] < ffLim;
    end
endgenerate
wire [11:0] maxAbs01 = (absv[0] > absv[1]) ? absv[0] : absv[1];
wire [11:0] maxAbs = (maxAbs01 > absv[2]) ? maxAbs01 : absv[2];
wire wakeNow = |({axHi, axLo} & {evCfg_r[5:3], evCfg_r[2:0]}); // RULE12
wire ffNow = (ffThr_r[6:0] != 7'h00) & (&axFf); // RULE12
wire is4d = evCfg_r[`ACMSC_B_EV4D];
wire [5:0] orientNow = {axHi[0], axLo[0], axHi[1], axLo[1],
    axHi[2] & ~is4d, axLo[2] & ~is4d}; // RULE6
// a sample counts only once the turn-on or mode-change wait has ended
wire smpOk = smpValid & ~trimBusy & (waitCyc_r == 20'h00000)
    & (waitSmp_r == 3'h0) & (odrSel != `ACMSC_ODR_OFF);
wire orientEv = smpOk & evCfg_r[`ACMSC_B_EV6D] & (orientNow != 6'h00)
    & (orientNow == orientPrev_r) & (orientNow != orientRep_r); // RULE6
// resolution mask keeps 12, 10 or 8 significant bits, left justified
wire [11:0] resMask = (resSel == `ACMSC_RES_HI) ? 12'hfff :
    (resSel == `ACMSC_RES_NM) ? 12'hffc : 12'hff0;
// fifo control
wire fifoOn = fifoMode != `ACMSC_FM_BYPASS;
wire fifoFull = fifoCnt_r == FIFO_DEPTH;
wire fifoStop = (fifoMode == `ACMSC_FM_FIFO) |
    ((fifoMode == `ACMSC_FM_TRIG) & trigHit_r);
wire fifoPop = rdZh & fifoOn & (fifoCnt_r != 0);
wire fifoPush = smpOk & fifoOn & ~(fifoFull & fifoStop); // RULE14
wire fifoDrop = fifoPush & fifoFull & ~fifoPop;
// turn-on and change waits
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        odrSel <= `ACMSC_ODR_OFF;
        resSel <= `ACMSC_RES_NM;
        bwSel <= 1'b0;
        waitCyc_r <= 20'h00000;
        waitSmp_r <= 3'h0;
    end else begin
        odrSel <= odrEff;
        resSel <= resEff;
        bwSel <= resEff == `ACMSC_RES_HI; // RULE2
        if (odrEff == `ACMSC_ODR_OFF) begin
            waitCyc_r <= 20'h00000;
            waitSmp_r <= 3'h0;
        end else if (odrSel == `ACMSC_ODR_OFF) begin
            // leaving power-down: fixed time or seven periods
            if (resEff == `ACMSC_RES_HI) begin
                waitSmp_r <= `ACMSC_SKIP_HI; // RULE3
            end else if (resEff == `ACMSC_RES_LP) begin
                waitCyc_r <= TON_LP_CYC[19:0]; // RULE3
            end else begin
                waitCyc_r <= TON_NM_CYC[19:0]; // RULE3
            end
        end else if (resEff != resSel) begin
            waitCyc_r <= 20'h00000;
            waitSmp_r <= (resEff == `ACMSC_RES_HI) ?
                `ACMSC_SKIP_HI : `ACMSC_SKIP_OTHER; // RULE4
        end else begin
            if (waitCyc_r != 20'h00000) begin
                waitCyc_r <= waitCyc_r - 20'h00001;
            end
            if (smpValid && waitSmp_r != 3'h0) begin
                waitSmp_r <= waitSmp_r - 3'h1;
            end
        end
    end
end
// trimming download, three words, before any other activity
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        trimStep_r <= 3'h0;
        trimAddr <= 2'h0;
        trimBusy <= 1'b1;
        trimOff_r[0] <= 12'h000;
        trimOff_r[1] <= 12'h000;
        trimOff_r[2] <= 12'h000;
    end else if (trimBusy) begin
        trimStep_r <= trimStep_r + 3'h1;
        if (trimAddr != `ACMSC_TRIM_WORDS) begin
            trimAddr <= trimAddr + 2'h1;
        end
        if (trimStep_r != 3'h0) begin
            trimOff_r[trimStep_r[1:0] - 2'h1] <= trimData; // RULE13
        end
        trimBusy <= trimStep_r != {1'b0, `ACMSC_TRIM_WORDS};
    end
end
// register file
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        ratePwr_r <= `ACMSC_RST_RATEPWR;
        ctrl3_r <= `ACMSC_RST_ZERO;
        resUpd_r <= `ACMSC_RST_ZERO;
        tempCfg_r <= `ACMSC_RST_ZERO;
        fifoCtl_r <= `ACMSC_RST_ZERO;
        evCfg_r <= `ACMSC_RST_ZERO;
        wakeThr_r <= `ACMSC_RST_ZERO;
        ffThr_r <= `ACMSC_RST_ZERO;
        actThr_r <= `ACMSC_RST_ZERO;
        actDur_r <= `ACMSC_RST_ZERO;
    end else if (wrHit) begin
        case (regAddr)
            `ACMSC_A_RATEPWR: ratePwr_r <= regWdata;
            `ACMSC_A_CTRL3: ctrl3_r <= regWdata;
            `ACMSC_A_RESUPD: resUpd_r <= regWdata;
            `ACMSC_A_TEMPCFG: tempCfg_r <= regWdata;
            `ACMSC_A_FIFOCTL: fifoCtl_r <= regWdata;
            `ACMSC_A_EVCFG: evCfg_r <= regWdata;
            `ACMSC_A_WAKETHR: wakeThr_r <= regWdata;
            `ACMSC_A_FFTHR: ffThr_r <= regWdata;
            `ACMSC_A_ACTTHR: actThr_r <= regWdata; // RULE7
            `ACMSC_A_ACTDUR: actDur_r <= regWdata; // RULE7
            default: ;
        endcase
    end
end
// sample path: outputs, ready flag, sleep fallback, events
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        outReg_r[0] <= 16'h0000;
        outReg_r[1] <= 16'h0000;
        outReg_r[2] <= 16'h0000;
        readyFlag_r <= 1'b0;
        sleep_r <= 1'b0;
        durCnt_r <= 8'h00;
        orientPrev_r <= 6'h00;
        orientRep_r <= 6'h00;
        evSrc_r <= 8'h00;
        sleepActive <= 1'b0;
        dataReady <= 1'b0;
        eventPinOne <= 1'b0;
        eventPinTwo <= 1'b0;
    end else begin
        if (smpOk) begin
            outReg_r[0] <= {corr[0] & resMask, 4'h0}; // RULE19
            outReg_r[1] <= {corr[1] & resMask, 4'h0}; // RULE19
            outReg_r[2] <= {corr[2] & resMask, 4'h0}; // RULE19
            orientPrev_r <= orientNow;
            if (orientEv) begin
                orientRep_r <= orientNow;
            end
            evSrc_r <= {ffNow, orientEv, axHi, axLo};
        end
        // a new set wins over the clearing read in the same cycle
        if (smpOk) begin
            readyFlag_r <= 1'b1; // RULE11
        end else if (rdZh) begin
            readyFlag_r <= 1'b0;
        end
        if (actThr_r[6:0] == 7'h00) begin
            sleep_r <= 1'b0;
            durCnt_r <= 8'h00;
        end else if (smpValid && !trimBusy) begin
            if (maxAbs < actLim) begin
                if (durCnt_r >= actDur_r) begin
                    sleep_r <= 1'b1; // RULE8
                end else begin
                    durCnt_r <= durCnt_r + 8'h01;
                end
            end else begin
                sleep_r <= 1'b0; // RULE10
                durCnt_r <= 8'h00;
            end
        end
        sleepActive <= sleep_r;
        dataReady <= readyFlag_r; // RULE11
        eventPinOne <= (ctrl3_r[`ACMSC_B_PIN1WAKE]
            & (evSrc_r[6] | (|evSrc_r[5:0] & wakeNow)))
            | (ctrl3_r[`ACMSC_B_PIN1RDY] & readyFlag_r); // RULE12
        eventPinTwo <= evSrc_r[7]; // RULE12
    end
end
// trigger latch: a wake event freezes stream into fifo behaviour
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        trigHit_r <= 1'b0;
    end else if (fifoMode != `ACMSC_FM_TRIG) begin
        trigHit_r <= 1'b0;
    end else if (smpOk && wakeNow) begin
        trigHit_r <= 1'b1; // RULE14
    end
end
// fifo pointers; bypass holds it empty
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        wrPtr_r <= {FIFO_AW{1'b0}};
        rdPtr_r <= {FIFO_AW{1'b0}};
        fifoCnt_r <= {(FIFO_AW+1){1'b0}};
    end else if (!fifoOn) begin
        wrPtr_r <= {FIFO_AW{1'b0}}; // RULE15
        rdPtr_r <= {FIFO_AW{1'b0}}; // RULE15
        fifoCnt_r <= {(FIFO_AW+1){1'b0}}; // RULE15
    end else begin
        if (fifoPush) begin
            wrPtr_r <= wrPtr_r + 1'b1; // RULE15
        end
        // stream overwrites the oldest set when full
        if (fifoPop || fifoDrop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
        end
        if (fifoPush && !fifoPop && !fifoFull) begin
            fifoCnt_r <= fifoCnt_r + 1'b1;
        end else if (fifoPop && !fifoPush) begin
            fifoCnt_r <= fifoCnt_r - 1'b1;
        end
    end
end
// entries keep the ten most significant bits of each axis
always @(posedge clk) begin
    if (fifoPush) begin
        fifoMem[{wrPtr_r, 2'h0} - wrPtr_r] <= corr[0][11:2]; // RULE14
        fifoMem[{wrPtr_r, 2'h0} - wrPtr_r + 1'b1] <= corr[1][11:2];
        fifoMem[{wrPtr_r, 2'h0} - wrPtr_r + 2'h2] <= corr[2][11:2];
    end
end

// temperature: zero while disabled, pair held by block_update_hold
wire tempEn = tempCfg_r[`ACMSC_B_TEMPEN];
wire holdOn = resUpd_r[`ACMSC_B_HOLD];
always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        tempOut_r <= 8'h00;
        tempHold_r <= 8'h00;
        tempLock_r <= 1'b0;
    end else begin
        if (!tempEn) begin
            tempOut_r <= 8'h00; // RULE16
        end else if (smpOk) begin
            tempOut_r <= tempRaw; // RULE18
        end
        if (regRd && regAddr == `ACMSC_A_TEMPL && holdOn) begin
            tempLock_r <= 1'b1; // RULE17
        end else if (regRd && regAddr == `ACMSC_A_TEMPH) begin
            tempLock_r <= 1'b0; // RULE17
        end
        if (!(tempLock_r && holdOn)) begin
            tempHold_r <= tempOut_r;
        end
    end
end

// read mux; in fifo modes the output bytes come from the oldest set
wire [FIFO_AW+1:0] headBase = {rdPtr_r, 2'h0} - rdPtr_r;
wire [1:0] axSel = regAddr[2:1];
wire [9:0] headEnt = fifoMem[headBase + axSel];
wire [15:0] outWord = fifoOn ? {headEnt, 6'h00} : outReg_r[axSel];
wire outArea = (regAddr >= `ACMSC_A_OUTXL) && (regAddr <= `ACMSC_A_OUTZH);
reg [7:0] rdMux;
always @* begin
    rdMux = 8'h00;
    if (outArea) begin
        rdMux = regAddr[0] ? outWord[15:8] : outWord[7:0];
    end else begin
        case (regAddr)
            `ACMSC_A_TEMPH: rdMux = tempHold_r; // RULE18
            `ACMSC_A_TEMPCFG: rdMux = tempCfg_r;
            `ACMSC_A_RATEPWR: rdMux = ratePwr_r;
            `ACMSC_A_CTRL3: rdMux = ctrl3_r;
            `ACMSC_A_RESUPD: rdMux = resUpd_r;
            `ACMSC_A_STATUS: rdMux = {4'h0, readyFlag_r, 3'h0}; // RULE11
            `ACMSC_A_FIFOCTL: rdMux = fifoCtl_r;
            `ACMSC_A_FIFOSRC: rdMux = {1'b0, fifoFull, fifoCnt_r};
            `ACMSC_A_EVCFG: rdMux = evCfg_r;
            `ACMSC_A_EVSRC: rdMux = evSrc_r;
            `ACMSC_A_WAKETHR: rdMux = wakeThr_r;
            `ACMSC_A_FFTHR: rdMux = ffThr_r;
            `ACMSC_A_ACTTHR: rdMux = actThr_r;
            `ACMSC_A_ACTDUR: rdMux = actDur_r;
            default: rdMux = 8'h00;
        endcase
    end
end

always @(posedge clk or negedge rstI_n) begin
    if (!rstI_n) begin
        regRdata <= 8'h00;
    end else if (regRd) begin
        regRdata <= rdMux;
    end
end

endmodule // acmsc_core

// *** testbench/acmsc_trim_store.sv ***
`timescale 1ns/1ns
module acmsc_trim_store #(
    parameter [11:0] TRIM_FILL = 12'h000
) (
    input wire clk, // device clock
    input wire [1:0] trimAddr, // word address from the download logic
    input wire trimBusy, // download in progress
    output reg [11:0] trimData // word, one cycle after its address
);
    initial trimData = 12'h000;
    // zero trim keeps the sample expectations of the bench exact
    always @(posedge clk) begin
        if (trimBusy) begin
            trimData <= (trimAddr == 2'h3) ? ~TRIM_FILL : TRIM_FILL;
        end else begin
            // storage released: flip so a stale read cannot pass
            trimData <= ~trimData;
        end
    end
endmodule // acmsc_trim_store

// *** testbench/acmsc_checker.sv ***
`timescale 1ns/1ns
module acmsc_checker (
    input wire clk, // clock
    input wire rst_n, // reset, active low
    input wire regWr, // write strobe
    input wire [6:0] regAddr, // address
    input wire [7:0] regWdata, // write data
    input wire smpValid, // sample pulse
    input wire trimBusy, // trim download
    input wire [3:0] odrSel, // effective rate
    input wire [1:0] resSel, // effective resolution
    input wire bwSel, // bandwidth select
    input wire sleepActive, // fallback active
    input wire dataReady, // ready level
    input wire eventPinTwo // free-fall pin
);
    reg [3:0] progOdr_r;
    reg progLp_r;
    reg progHr_r;
    wire [1:0] progRes;
    assign progRes = (progHr_r && !progLp_r) ? 2'h2 :
        ((progLp_r && !progHr_r) ? 2'h0 : 2'h1);
    // shadow of the programmed mode; writes during download are dropped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progOdr_r <= 4'h0;
            progLp_r <= 1'b0;
            progHr_r <= 1'b0;
        end else if (regWr && !trimBusy) begin
            if (regAddr == 7'h20) begin
                progOdr_r <= regWdata[7:4];
                progLp_r <= regWdata[3];
            end
            if (regAddr == 7'h23) begin
                progHr_r <= regWdata[3];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_trim_hold;
        trimBusy [*5];
    endsequence
    sequence s_rate_write;
        regWr && regAddr == 7'h20 && !trimBusy && !sleepActive
            ##1 !sleepActive [*2];
    endsequence
    a_res_legal: assert property (resSel != 2'h3)
        else $error("reserved resolution code");
    a_bw_match: assert property (bwSel == (resSel == 2'h2))
        else $error("bandwidth does not follow resolution");
    a_trim_release: assert property (
        $rose(rst_n) |-> s_trim_hold ##[1:6] !trimBusy)
        else $error("trim download length wrong");
    a_busy_quiet: assert property (
        trimBusy |-> !dataReady && !sleepActive)
        else $error("activity during trim download");
    a_ready_cause: assert property (
        $rose(dataReady) |-> $past(smpValid, 2))
        else $error("ready without a sample");
    a_ff_cause: assert property (
        $rose(eventPinTwo) |-> $past(smpValid, 2))
        else $error("free-fall without a sample");
    a_sleep_mode: assert property (
        sleepActive [*3] |-> odrSel == 4'h2 && resSel == 2'h0)
        else $error("fallback mode wrong");
    a_wake_restore: assert property (
        $fell(sleepActive) |-> ##[0:2]
            (odrSel == progOdr_r && resSel == progRes))
        else $error("mode not restored");
    a_rate_follow: assert property (
        s_rate_write |-> odrSel == progOdr_r)
        else $error("rate does not follow write");
endmodule // acmsc_checker
bind acmsc_core acmsc_checker u_chk (.clk(clk), .rst_n(rst_n),
    .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
    .smpValid(smpValid), .trimBusy(trimBusy), .odrSel(odrSel),
    .resSel(resSel), .bwSel(bwSel), .sleepActive(sleepActive),
    .dataReady(dataReady), .eventPinTwo(eventPinTwo));

// *** testbench/tb_accel_mode_and_sleep_control.sv ***
`timescale 1ns/1ns
`include "acmsc_defs.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    fails = fails + 1; $display("Error at %0t: got %h want %h", $time, \
    g, e); end end
module tb_accel_mode_and_sleep_control;
    localparam TON_NM = 32;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg regWr = 1'b0, regRd = 1'b0, smpValid = 1'b0;
    reg [6:0] regAddr = 7'h00;
    reg [7:0] regWdata = 8'h00, tempRaw = 8'h85, v;
    reg [11:0] smpX = 12'h000, smpY = 12'h000, smpZ = 12'h000;
    reg [11:0] stForce = 12'h010;
    wire [7:0] regRdata;
    wire [11:0] trimData;
    wire [1:0] trimAddr, resSel;
    wire [3:0] odrSel;
    wire trimBusy, bwSel, sleepActive, dataReady, eventPinOne, eventPinTwo;
    integer fails = 0, compares = 0, i;
    always #2 clk = ~clk;
    acmsc_core #(.TON_LP_CYC(20), .TON_NM_CYC(TON_NM), .FIFO_DEPTH(32),
        .FIFO_AW(5)) dut (.clk(clk), .rst_n(rst_n), .regWr(regWr),
        .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .smpValid(smpValid), .smpX(smpX), .smpY(smpY),
        .smpZ(smpZ), .stForce(stForce), .tempRaw(tempRaw),
        .trimData(trimData), .trimAddr(trimAddr), .trimBusy(trimBusy),
        .odrSel(odrSel), .resSel(resSel), .bwSel(bwSel),
        .sleepActive(sleepActive), .dataReady(dataReady),
        .eventPinOne(eventPinOne), .eventPinTwo(eventPinTwo));
    acmsc_trim_store nvm (.clk(clk), .trimAddr(trimAddr),
        .trimBusy(trimBusy), .trimData(trimData));
    task results;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        begin
            @(posedge clk) #1;
            regWr = 1'b1;
            regAddr = a;
            regWdata = d;
            @(posedge clk) #1;
            regWr = 1'b0;
        end
    endtask
    task rdc(input [6:0] a, input [7:0] e);
        begin
            @(posedge clk) #1;
            regRd = 1'b1;
            regAddr = a;
            @(posedge clk) #1;
            regRd = 1'b0;
            `CHK(regRdata, e)
            v = regRdata;
        end
    endtask
    task rdy(input e);
        begin
            rdc(`ACMSC_A_STATUS, {4'h0, e, 3'h0});
            `CHK(v[`ACMSC_B_READY], e)
        end
    endtask
    // three idle cycles let ready and the pins settle before a look
    task feed(input integer n, input [11:0] x);
        begin
            repeat (n) begin
                @(posedge clk) #1;
                smpValid = 1'b1;
                smpX = x;
                smpY = x;
                smpZ = x;
                @(posedge clk) #1;
                smpValid = 1'b0;
                repeat (3) @(posedge clk);
                #1;
            end
        end
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        results;
    end
    initial begin
        repeat (4) @(posedge clk);
        `CHK(resSel, 2'h1)
        #1 rst_n = 1'b1;
        i = 0;
        while (trimBusy !== 1'b0 && i < 20) begin
            @(posedge clk);
            i = i + 1;
        end
        #1 `CHK(trimBusy, 1'b0)
        if (trimBusy !== 1'b0) results;
        rdc(`ACMSC_A_RATEPWR, 8'h07);
        rdc(`ACMSC_A_CTRL3, 8'h00);
        rdc(`ACMSC_A_RESUPD, 8'h00);
        rdc(7'h10, 8'h00);
        wr(`ACMSC_A_ACTTHR, 8'ha5);
        wr(`ACMSC_A_ACTDUR, 8'h5a);
        rdc(`ACMSC_A_ACTTHR, 8'ha5);
        rdc(`ACMSC_A_ACTDUR, 8'h5a);
        wr(`ACMSC_A_ACTTHR, 8'h00);
        $display("test registers done");
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ACMSC_A_RATEPWR, {4'h0, i[1], 3'h7});
            wr(`ACMSC_A_RESUPD, {4'h0, i[0], 3'h0});
            repeat (3) @(posedge clk);
            `CHK(resSel, (i == 1) ? 2'h2 : ((i == 2) ? 2'h0 : 2'h1))
            `CHK(bwSel, (i == 1))
        end
        $display("test modes done");
        wr(`ACMSC_A_RESUPD, 8'h00);
        wr(`ACMSC_A_RATEPWR, 8'h57);
        feed(1, 12'h000);
        rdy(1'b0);
        repeat (TON_NM) @(posedge clk);
        feed(1, 12'h000);
        rdy(1'b1);
        `CHK(dataReady, 1'b1)
        rdc(`ACMSC_A_TEMPH, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            rdc(`ACMSC_A_OUTXL + i[6:0], 8'h00);
        end
        $display("test turn-on done");
        wr(`ACMSC_A_RESUPD, 8'h08);
        for (i = 0; i < 7; i = i + 1) begin
            feed(1, 12'h123);
            rdy(1'b0);
        end
        feed(1, 12'h123);
        rdy(1'b1);
        rdc(`ACMSC_A_OUTXL, 8'h30);
        rdc(`ACMSC_A_OUTXL + 7'h1, 8'h12);
        // a self-test change leaves the resolution alone and drops no sets
        wr(`ACMSC_A_RESUPD, 8'h0a);
        feed(9, 12'h123);
        rdc(`ACMSC_A_OUTXL + 7'h1, 8'h13);
        wr(`ACMSC_A_RESUPD, 8'h0c);
        feed(9, 12'h123);
        rdc(`ACMSC_A_OUTXL + 7'h1, 8'h11);
        $display("test output done");
        wr(`ACMSC_A_TEMPCFG, 8'h40);
        wr(`ACMSC_A_RESUPD, 8'h88);
        feed(1, 12'h000);
        rdc(`ACMSC_A_TEMPL, 8'h00);
        rdc(`ACMSC_A_TEMPH, 8'h85);
        wr(`ACMSC_A_CTRL3, 8'h10);
        wr(`ACMSC_A_EVCFG, 8'h07);
        wr(`ACMSC_A_FFTHR, 8'h10);
        feed(1, 12'h000);
        `CHK(eventPinOne, 1'b1)
        `CHK(eventPinTwo, 1'b1)
        feed(1, 12'h7ff);
        `CHK(eventPinTwo, 1'b0)
        wr(`ACMSC_A_FFTHR, 8'h00);
        $display("test temperature and events done");
        rdc(`ACMSC_A_FIFOSRC, 8'h00);
        wr(`ACMSC_A_FIFOCTL, 8'h40);
        feed(33, 12'h000);
        rdc(`ACMSC_A_FIFOSRC, 8'h60);
        // stream drops the oldest set when full; reading Z high pops one
        wr(`ACMSC_A_FIFOCTL, 8'h80);
        feed(1, 12'h123);
        rdc(`ACMSC_A_FIFOSRC, 8'h60);
        rdc(`ACMSC_A_OUTZH, 8'h00);
        rdc(`ACMSC_A_FIFOSRC, 8'h1f);
        wr(`ACMSC_A_FIFOCTL, 8'h00);
        rdc(`ACMSC_A_FIFOSRC, 8'h00);
        $display("test fifo done");
        wr(`ACMSC_A_ACTDUR, 8'h02);
        wr(`ACMSC_A_ACTTHR, 8'h10);
        feed(2, 12'h000);
        `CHK(sleepActive, 1'b0)
        feed(1, 12'h000);
        `CHK(sleepActive, 1'b1)
        `CHK(odrSel, 4'h2)
        `CHK(resSel, 2'h0)
        i = 0;
        while (sleepActive !== 1'b0 && i < 4) begin
            feed(1, 12'h7ff);
            i = i + 1;
        end
        `CHK(sleepActive, 1'b0)
        if (sleepActive !== 1'b0) results;
        `CHK(odrSel, 4'h5)
        `CHK(resSel, 2'h2)
        $display("test sleep done");
        results;
    end
endmodule // tb_accel_mode_and_sleep_control
